/* File: dac_ctl_pkg.sv */
// dac_ctl_pkg: constants shared by the audio dac control port design
// assumes: imported by the receiver, the control port, the monitor and the testbench; serial_frame_if does not import it
package dac_ctl_pkg;

  // ------------------------------------------------------------------
  // control word layout
  // ------------------------------------------------------------------
  localparam int unsigned WORD_BITS = 16;
  localparam int unsigned INDEX_MSB = 14;
  localparam int unsigned INDEX_LSB = 8;
  localparam int unsigned DATA_MSB  = 7;
  localparam logic [4:0]  WORD_BITS_CNT = 5'h10;

  // ------------------------------------------------------------------
  // register indices
  // ------------------------------------------------------------------
  localparam logic [6:0] INDEX_LEFT_ATTEN  = 7'h01;
  localparam logic [6:0] INDEX_RIGHT_ATTEN = 7'h02;
  localparam logic [6:0] INDEX_FORMAT      = 7'h03;
  localparam logic [6:0] INDEX_POWER       = 7'h04;

  // ------------------------------------------------------------------
  // reset values and field positions
  // ------------------------------------------------------------------
  localparam logic [7:0] RST_LEFT_ATTEN  = 8'h3f;
  localparam logic [7:0] RST_RIGHT_ATTEN = 8'h3f;
  localparam logic [7:0] RST_FORMAT      = 8'h00;
  localparam logic [7:0] RST_POWER       = 8'h00;
  localparam int unsigned POWERDOWN_BIT  = 0;
  localparam int unsigned MIX_BIT        = 4;
  localparam int unsigned DEEMPH_BIT     = 3;
  localparam logic [2:0] FORMAT_LJ24_SLAVE = 3'h0;
  localparam logic [2:0] FORMAT_LJ_STRAP   = 3'h0;
  localparam logic [2:0] FORMAT_I2S_STRAP  = 3'h1;
  localparam logic [2:0] FORMAT_MASTER_MIN = 3'h4;

  // ------------------------------------------------------------------
  // master mode audio clocks: bit clock is 64 fs, word clock is fs
  // ------------------------------------------------------------------
  localparam logic [1:0] BITCLK_HALF_DIV      = 2'h1;
  localparam logic [4:0] BITCLK_PER_HALF_WORD = 5'h1f;

  // ------------------------------------------------------------------
  // wishbone register map (word addresses in bytes)
  // ------------------------------------------------------------------
  localparam logic [4:0] WB_LEFT_ATTEN  = 5'h00;
  localparam logic [4:0] WB_RIGHT_ATTEN = 5'h04;
  localparam logic [4:0] WB_FORMAT      = 5'h08;
  localparam logic [4:0] WB_POWER       = 5'h0c;
  localparam logic [4:0] WB_STATUS      = 5'h10;
  localparam logic [4:0] WB_CONTROL     = 5'h14;
  localparam logic [7:0] RST_CONTROL    = 8'h00;
  localparam int unsigned CTL_STRAP_BIT = 0;

endpackage : dac_ctl_pkg

/* File: serial_frame_if.sv */
// serial_frame_if: carries a completed control word from the receiver
// assumes: receiver and register file share clk_i
`timescale 1ns/10ps
interface serial_frame_if;
  logic       word_valid;
  logic [6:0] register_index;
  logic [7:0] word_data;
  logic       busy;

  modport rx (output word_valid, output register_index, output word_data, output busy);
  modport regs (input word_valid, input register_index, input word_data, input busy);
endinterface : serial_frame_if

/* File: ctl_serial_rx.sv */
// ctl_serial_rx: three-wire write-only control receiver
// assumes: pins already synchronised; clk_i much faster than the shift clock
`timescale 1ns/10ps
module ctl_serial_rx
  import dac_ctl_pkg::*;
(
  input  wire logic    clk_i,
  input  wire logic    rst_i,
  input  wire logic    sel_n_i,
  input  wire logic    sclk_i,
  input  wire logic    sdata_i,
  serial_frame_if.rx   frame
);

  logic        sclk_d;
  logic        sel_d;
  logic [15:0] shift;
  logic [4:0]  count;

  wire rise_sclk = sclk_i & ~sclk_d;
  wire sel_rise  = sel_n_i & ~sel_d;
  wire in_frame  = ~sel_n_i;

  always_ff @(posedge clk_i) begin
    sclk_d <= sclk_i;
    sel_d  <= sel_n_i;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i || sel_rise) begin
      count <= 5'h00;
      shift <= 16'h0000;
    end else if (in_frame && rise_sclk) begin
      shift <= {shift[14:0], sdata_i};
      if (count != 5'h1f) begin
        count <= count + 5'h01;
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      frame.word_valid <= 1'b0;
    end else begin
      frame.word_valid <= sel_rise && (count == WORD_BITS_CNT);
    end
  end

  always_ff @(posedge clk_i) begin
    frame.register_index <= shift[INDEX_MSB:INDEX_LSB];
    frame.word_data      <= shift[DATA_MSB:0];
    frame.busy           <= in_frame;
  end

endmodule : ctl_serial_rx

/* File: audio_dac_control_port.sv */
// audio_dac_control_port: mode registers, strap variant and master clocks
// assumes: control pins and straps come from outside clk_i; wishbone is on clk_i
//
// The register addresses and register access over Wishbone were left to the implementer.
`timescale 1ns/10ps
module audio_dac_control_port
  import dac_ctl_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ctl_select_n_i,
  input  wire logic        ctl_shift_clock_i,
  input  wire logic        ctl_serial_in_i,
  input  wire logic        format_select_i,
  input  wire logic        deemphasis_select_i,
  input  wire logic        analog_mix_select_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [4:0]  adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  output logic             audio_bit_clock_o,
  output logic             word_clock_o,
  output logic             master_mode_o,
  output logic      [2:0]  format_o,
  output logic             deemphasis_o,
  output logic             analog_mix_o,
  output logic             soft_powerdown_o,
  output logic      [7:0]  left_atten_o,
  output logic      [7:0]  right_atten_o
);

  // ------------------------------------------------------------------
  // pin synchronisers, two flops each
  // ------------------------------------------------------------------
  // the strap pins share this pipe; they are read only in strap mode
  logic [5:0] pin_meta;
  logic [5:0] pin_sync;

  always_ff @(posedge clk_i) begin
    pin_meta <= {ctl_select_n_i, ctl_shift_clock_i, ctl_serial_in_i,
                 format_select_i, deemphasis_select_i, analog_mix_select_i};
    pin_sync <= pin_meta;
  end

  // ------------------------------------------------------------------
  // serial receiver
  // ------------------------------------------------------------------
  // a finished word is handed over one cycle after select rises
  serial_frame_if frame ();

  ctl_serial_rx u_rx (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .sel_n_i (pin_sync[5]),
    .sclk_i  (pin_sync[4]),
    .sdata_i (pin_sync[3]),
    .frame   (frame)
  );

  // ------------------------------------------------------------------
  // mode registers
  // ------------------------------------------------------------------
  logic [7:0] left_atten;
  logic [7:0] right_atten;
  logic [7:0] format_reg;
  logic [7:0] power_reg;
  logic [7:0] control_reg;

  // ------------------------------------------------------------------
  // register decode, shared by the write strobes and the read mux
  // ------------------------------------------------------------------
  function automatic logic adr_is(input logic [4:0] adr, input logic [4:0] offset);
    adr_is = (adr == offset);
  endfunction : adr_is

  // only byte lane 0 carries register data
  wire wb_req   = cyc_i & stb_i & ~ack_o;
  wire wb_write = wb_req & we_i & sel_i[0];
  wire ser_wr   = frame.word_valid;
  wire hit_l    = ser_wr && (frame.register_index == INDEX_LEFT_ATTEN);
  wire hit_r    = ser_wr && (frame.register_index == INDEX_RIGHT_ATTEN);
  wire hit_f    = ser_wr && (frame.register_index == INDEX_FORMAT);
  wire hit_p    = ser_wr && (frame.register_index == INDEX_POWER);
  wire wb_l     = wb_write && adr_is(adr_i, WB_LEFT_ATTEN);
  wire wb_r     = wb_write && adr_is(adr_i, WB_RIGHT_ATTEN);
  wire wb_f     = wb_write && adr_is(adr_i, WB_FORMAT);
  wire wb_p     = wb_write && adr_is(adr_i, WB_POWER);
  wire wb_c     = wb_write && adr_is(adr_i, WB_CONTROL);

  // serial writes win over a simultaneous bus write to the same register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      left_atten  <= RST_LEFT_ATTEN;
      right_atten <= RST_RIGHT_ATTEN;
      format_reg  <= RST_FORMAT;
      power_reg   <= RST_POWER;
      control_reg <= RST_CONTROL;
    end else begin
      if (hit_l) left_atten <= frame.word_data;
      else if (wb_l) left_atten <= dat_i[7:0];
      if (hit_r) right_atten <= frame.word_data;
      else if (wb_r) right_atten <= dat_i[7:0];
      if (hit_f) format_reg <= frame.word_data;
      else if (wb_f) format_reg <= dat_i[7:0];
      if (hit_p) power_reg <= frame.word_data;
      else if (wb_p) power_reg <= dat_i[7:0];
      if (wb_c) control_reg <= dat_i[7:0];
    end
  end

  // ------------------------------------------------------------------
  // effective mode: strap variant or register
  // ------------------------------------------------------------------
  // strap mode ignores the power register and forces slave operation
  wire       strap_mode = control_reg[CTL_STRAP_BIT];
  wire [2:0] next_format = strap_mode ?
                           (pin_sync[2] ? FORMAT_I2S_STRAP : FORMAT_LJ_STRAP)
                           : format_reg[2:0];
  wire next_deemph = strap_mode ? pin_sync[1] : format_reg[DEEMPH_BIT];
  wire next_mix    = strap_mode ? pin_sync[0] : format_reg[MIX_BIT];
  wire next_master = ~strap_mode && (format_reg[2:0] >= FORMAT_MASTER_MIN);
  wire powerdown   = ~strap_mode && power_reg[POWERDOWN_BIT];

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      format_o         <= FORMAT_LJ24_SLAVE;
      deemphasis_o     <= 1'b0;
      analog_mix_o     <= 1'b0;
      master_mode_o    <= 1'b0;
      soft_powerdown_o <= 1'b0;
      left_atten_o     <= RST_LEFT_ATTEN;
      right_atten_o    <= RST_RIGHT_ATTEN;
    end else begin
      format_o         <= next_format;
      deemphasis_o     <= next_deemph;
      analog_mix_o     <= next_mix;
      master_mode_o    <= next_master;
      soft_powerdown_o <= powerdown;
      left_atten_o     <= left_atten;
      right_atten_o    <= right_atten;
    end
  end

  // ------------------------------------------------------------------
  // master clocks: clk_i stands for the 256 fs system clock
  // ------------------------------------------------------------------
  // bitclk_cnt counts bit clock falls; the word clock flips after 32 of them
  logic [1:0] div_cnt;
  logic [4:0] bitclk_cnt;
  wire        logic_hold    = rst_i || powerdown || ~next_master;
  wire        bitclk_toggle = (div_cnt == BITCLK_HALF_DIV);

  always_ff @(posedge clk_i) begin
    if (logic_hold) begin
      div_cnt           <= 2'h0;
      bitclk_cnt        <= 5'h00;
      audio_bit_clock_o <= 1'b0;
      word_clock_o      <= 1'b0;
    end else begin
      div_cnt <= bitclk_toggle ? 2'h0 : div_cnt + 2'h1;
      if (bitclk_toggle) begin
        audio_bit_clock_o <= ~audio_bit_clock_o;
        if (audio_bit_clock_o) begin
          bitclk_cnt <= bitclk_cnt + 5'h01;
          if (bitclk_cnt == BITCLK_PER_HALF_WORD) begin
            word_clock_o <= ~word_clock_o;
          end
        end
      end
    end
  end

  // ------------------------------------------------------------------
  // wishbone read and acknowledge, one wait state
  // ------------------------------------------------------------------
  // ack is registered, so a request is answered one cycle after it is taken
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = 32'h0000_0000;
    if (adr_is(adr_i, WB_LEFT_ATTEN)) next_rdata[7:0] = left_atten;
    else if (adr_is(adr_i, WB_RIGHT_ATTEN)) next_rdata[7:0] = right_atten;
    else if (adr_is(adr_i, WB_FORMAT)) next_rdata[7:0] = format_reg;
    else if (adr_is(adr_i, WB_POWER)) next_rdata[7:0] = power_reg;
    else if (adr_is(adr_i, WB_STATUS))
      next_rdata[5:0] = {frame.busy, master_mode_o, format_o, soft_powerdown_o};
    else if (adr_is(adr_i, WB_CONTROL)) next_rdata[7:0] = control_reg;
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= wb_req;
      dat_o <= wb_req ? next_rdata : 32'h0000_0000;
    end
  end

endmodule : audio_dac_control_port

/* File: dac_ctl_monitor.sv */
// dac_ctl_monitor: assertions on the control port pins
// assumes: bound to audio_dac_control_port, one clk_i domain
`timescale 1ns/10ps
module dac_ctl_monitor
  import dac_ctl_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ctl_select_n_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic [31:0] dat_o,
  input  wire logic        ack_o,
  input  wire logic        audio_bit_clock_o,
  input  wire logic        word_clock_o,
  input  wire logic        master_mode_o,
  input  wire logic [2:0]  format_o,
  input  wire logic        soft_powerdown_o,
  input  wire logic [7:0]  left_atten_o
);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  chk_ack_one_cycle:
    assert property (ack_o |=> !ack_o) else $error("ack held too long");
  chk_ack_latency:
    assert property (cyc_i && stb_i && !ack_o |=> ack_o) else $error("ack late");
  chk_data_idle:
    assert property (!ack_o |-> dat_o == 32'h0) else $error("read data without ack");
  chk_reset_values:
    assert property ($fell(rst_i) |->
      format_o == FORMAT_LJ24_SLAVE && left_atten_o == RST_LEFT_ATTEN)
      else $error("bad reset values");
  chk_clocks_idle:
    assert property (!master_mode_o [*3] |-> !audio_bit_clock_o && !word_clock_o)
      else $error("audio clocks run outside master mode");
  chk_bck_period:
    assert property ($rose(audio_bit_clock_o) |=>
      (audio_bit_clock_o || soft_powerdown_o || !master_mode_o) ##1
      (!audio_bit_clock_o || soft_powerdown_o || !master_mode_o))
      else $error("bad bit clock period");
  chk_wclk_hold:
    assert property ($rose(word_clock_o) |=>
      (word_clock_o || !master_mode_o || soft_powerdown_o) [*8]) else $error("short wclk");
  chk_master_format:
    assert property (master_mode_o |-> format_o[2]) else $error("master with low format");
  chk_commit_frame:
    assert property ($changed(left_atten_o) && !$past(rst_i) && !ack_o && !$past(ack_o)
      |-> $past(ctl_select_n_i, 4)) else $error("register changed inside a frame");
  cov_master: cover property ($rose(master_mode_o));
  cov_ack: cover property ($rose(ack_o));
  cov_commit: cover property ($changed(left_atten_o));
endmodule : dac_ctl_monitor

bind audio_dac_control_port dac_ctl_monitor u_mon (
  .clk_i(clk_i), .rst_i(rst_i), .ctl_select_n_i(ctl_select_n_i), .cyc_i(cyc_i),
  .stb_i(stb_i), .dat_o(dat_o), .ack_o(ack_o), .audio_bit_clock_o(audio_bit_clock_o),
  .word_clock_o(word_clock_o), .master_mode_o(master_mode_o), .format_o(format_o),
  .soft_powerdown_o(soft_powerdown_o), .left_atten_o(left_atten_o));

/* File: ctl_host_model.sv */
// ctl_host_model: host side of the three-wire control port
// assumes: clk_i is the 100 ns bench clock; shift clock is 800 ns
`timescale 1ns/10ps
module ctl_host_model (
  input  wire logic clk_i,
  output logic      sel_n_o,
  output logic      sclk_o,
  output logic      sdata_o
);
  // ------------------------------------------------------------
  // frame driver
  // ------------------------------------------------------------
  initial begin
    sel_n_o = 1'b1;
    sclk_o  = 1'b0;
    sdata_o = 1'b0;
  end
  task automatic send(input logic [15:0] w, input int n);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      sclk_o  <= 1'b0;
      sel_n_o <= 1'b0;
      sdata_o <= w[15-i];
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b1;
      repeat (3) @(posedge clk_i);
    end
    @(posedge clk_i);
    sclk_o  <= 1'b0;
    sel_n_o <= 1'b1;
    sdata_o <= ~sdata_o;
    repeat (8) @(posedge clk_i);
  endtask : send
  task automatic spin(input int n);
    repeat (n) begin
      @(posedge clk_i);
      sclk_o  <= 1'b1;
      sdata_o <= ~sdata_o;
      repeat (4) @(posedge clk_i);
      sclk_o <= 1'b0;
      repeat (3) @(posedge clk_i);
    end
  endtask : spin
endmodule : ctl_host_model

/* File: testbench.sv */
// testbench: self-checking bench for the audio dac control port
// assumes: host model drives the serial pins, bench is wishbone master
`timescale 1ns/10ps
module testbench;
  import dac_ctl_pkg::*;
  logic        clk_i, rst_i, sel_n, sclk, sdata, frm_p, dem_p, mix_p, cyc_i, stb_i, we_i;
  logic        ack_o, bitclk, wclk, master, dem, mix, pd;
  logic [4:0]  adr_i;
  logic [31:0] dat_i, dat_o, rd;
  logic [2:0]  frm;
  logic [7:0]  latt, ratt;
  int          mismatches, num_checks;
  // ------------------------------------------------------------
  // harness
  // ------------------------------------------------------------
  ctl_host_model host (.clk_i(clk_i), .sel_n_o(sel_n), .sclk_o(sclk), .sdata_o(sdata));
  audio_dac_control_port DUT (.clk_i(clk_i), .rst_i(rst_i), .ctl_select_n_i(sel_n),
    .ctl_shift_clock_i(sclk), .ctl_serial_in_i(sdata), .format_select_i(frm_p),
    .deemphasis_select_i(dem_p), .analog_mix_select_i(mix_p), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(4'hf), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .audio_bit_clock_o(bitclk), .word_clock_o(wclk), .master_mode_o(master), .format_o(frm),
    .deemphasis_o(dem), .analog_mix_o(mix), .soft_powerdown_o(pd), .left_atten_o(latt),
    .right_atten_o(ratt));
  task automatic complete_run();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : complete_run
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  task automatic wb(input logic w, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    cyc_i <= 1'b1; stb_i <= 1'b1; we_i <= w; adr_i <= a; dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 40);
    if (n >= 40) begin
      mismatches++;
      complete_run();
    end
    rd = dat_o;
    cyc_i <= 1'b0; stb_i <= 1'b0;
    @(posedge clk_i);
  endtask : wb
  task automatic rises(input int n, output int r);
    logic p;
    r = 0;
    p = bitclk;
    repeat (n) begin
      @(posedge clk_i);
      if (bitclk && !p) r++;
      p = bitclk;
    end
  endtask : rises
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_serial();
    check("format", frm, FORMAT_LJ24_SLAVE);
    host.send({1'b0, INDEX_LEFT_ATTEN, 8'h15}, 16);
    host.send({1'b0, INDEX_RIGHT_ATTEN, 8'h2a}, 16);
    check("left", latt, 8'h15);
    check("right", ratt, 8'h2a);
    wb(1'b0, WB_LEFT_ATTEN, 32'h0);
    check("left rd", rd, 32'h15);
    host.send({1'b0, INDEX_LEFT_ATTEN, 8'h00}, 15);
    host.send({1'b0, 7'h05, 8'h00}, 16);
    host.spin(6);
    check("left kept", latt, 8'h15);
    $display("t_serial done");
  endtask : t_serial
  task automatic t_master();
    int r, c;
    logic pw;
    c = 0;
    host.send({1'b0, INDEX_FORMAT, 8'h1c}, 16);
    check("master", {master, dem, mix, frm}, 6'h3c);
    wb(1'b0, WB_STATUS, 32'h0);
    check("status", rd, 32'h18);
    rises(256, r);
    check("bit clock rises", r, 64);
    pw = wclk;
    repeat (256) begin
      @(posedge clk_i);
      if (wclk !== pw) c++;
      pw = wclk;
    end
    check("wclk edges", c, 2);
    host.send({1'b0, INDEX_POWER, 8'h01}, 16);
    rises(32, r);
    check("pd stop", {pd, r[3:0]}, 5'h10);
    check("kept", {frm, latt}, {3'h4, 8'h15});
    host.send({1'b0, INDEX_POWER, 8'h00}, 16);
    check("pd off", pd, 1'b0);
    $display("t_master done");
  endtask : t_master
  task automatic t_bus();
    wb(1'b1, WB_RIGHT_ATTEN, 32'h07);
    check("right wb", ratt, 8'h07);
    wb(1'b1, 5'h18, 32'hff);
    wb(1'b0, 5'h18, 32'h0);
    check("unmapped", rd, 32'h0);
    wb(1'b1, WB_CONTROL, 32'h1);
    frm_p <= 1'b1; dem_p <= 1'b1; mix_p <= 1'b0;
    repeat (6) @(posedge clk_i);
    check("strap i2s", {master, frm}, {1'b0, FORMAT_I2S_STRAP});
    check("strap pins", {dem, mix}, 2'h2);
    frm_p <= 1'b0; dem_p <= 1'b0; mix_p <= 1'b1;
    repeat (6) @(posedge clk_i);
    check("strap lj", frm, FORMAT_LJ_STRAP);
    check("strap pins2", {dem, mix}, 2'h1);
    $display("t_bus done");
  endtask : t_bus
  initial begin
    clk_i = 1'b0;
    forever #50 clk_i = ~clk_i; // stands for 256 fs, no bit clock driven
  end
  initial begin
    rst_i = 1'b1; cyc_i = 1'b0; stb_i = 1'b0; we_i = 1'b0; adr_i = 5'h0; dat_i = 32'h0;
    frm_p = 1'b0; dem_p = 1'b0; mix_p = 1'b0; mismatches = 0; num_checks = 0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (3) @(posedge clk_i);
    t_serial();
    t_master();
    t_bus();
    complete_run();
  end
endmodule : testbench
